// ==== bench/rtdcc_channel_regs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module rtdcc_channel_regs_chk
    import rtdcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err,
    input wire logic module_fail,
    input wire logic bus_suspect,
    input wire rtdcc_pkg::rtdcc_sensor_type sensor_type,
    input wire logic measure_resistance,
    input wire logic three_wire,
    input wire logic reject_60hz,
    input wire rtdcc_pkg::rtdcc_avg_type avg_mode,
    input wire logic [2:0] exp_stage,
    input wire logic resistance_fine,
    input wire logic error_lamp,
    input wire logic receive_lamp,
    input wire logic transmit_lamp
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Bus-side address decode
    wire logic strobe = reg_rd || reg_wr;
    wire logic mapped = reg_addr inside {ADDR_SCALED_MEASURE, ADDR_FLOAT_HIGH,
        ADDR_FLOAT_LOW, ADDR_LEAD_RESISTANCE, ADDR_CONFIG_WORD, ADDR_FALLBACK_VALUE};
    wire logic cfg_wr = reg_wr && reg_addr == ADDR_CONFIG_WORD;

    // Expected filter class and stage
    function automatic logic [4:0] fexp(input logic [2:0] c);
        return (c > 3'h2) ? {2'h3, c - 3'h2} : {c[1:0], 3'h0};
    endfunction : fexp

    map_ack_a: assert property (strobe && mapped |=> reg_ack && !reg_err)
        else $error("mapped access not acked");
    unmap_err_a: assert property (strobe && !mapped |=> reg_err && !reg_ack)
        else $error("unmapped access not refused");
    idle_quiet_a: assert property (!strobe |=> !reg_ack && !reg_err)
        else $error("answer without a request");
    cfg_fields_a: assert property (cfg_wr |=>
        {sensor_type, measure_resistance, three_wire} == $past(reg_wdata[7:4]))
        else $error("config fields wrong");
    reject_sel_a: assert property (cfg_wr |=> reject_60hz == $past(reg_wdata[3]))
        else $error("rejection select wrong");
    filter_dec_a: assert property (cfg_wr |=>
        {avg_mode, exp_stage} == fexp($past(reg_wdata[2:0])))
        else $error("filter decode wrong");
    cfg_upper_a: assert property (reg_rd && reg_addr == ADDR_CONFIG_WORD |=>
        reg_rdata[15:8] == 8'h00)
        else $error("unused config bits read back");
    fine_unit_a: assert property (cfg_wr |=>
        resistance_fine == ($past(reg_wdata[5]) && !$past(reg_wdata[7])))
        else $error("resistance unit wrong");
    fail_lamps_a: assert property (module_fail [*2] |-> error_lamp && transmit_lamp)
        else $error("failure lamps not steady");
    rx_steady_a: assert property (bus_suspect [*2] |-> receive_lamp)
        else $error("receive lamp not steady");

    cover property (reg_err);
    cover property (cfg_wr && reg_wdata[2:0] == 3'h7);
    cover property (module_fail && error_lamp);
endmodule : rtdcc_channel_regs_chk

bind rtdcc_channel_regs rtdcc_channel_regs_chk rtdcc_channel_regs_chk_inst (.*);

`default_nettype wire

// ==== bench/rtdcc_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Bus master polling the channel registers, one strobe per access
module rtdcc_master_model
(
    input wire logic sys_clk,
    output logic reg_rd,
    output logic reg_wr,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err
);
    // Idle lines show no stale address
    initial
    begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end

    // One-cycle strobe, answer taken a cycle later
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic ack, output logic err);
        @(posedge sys_clk);
        #1;
        reg_rd = !wr;
        reg_wr = wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        q = reg_rdata;
        ack = reg_ack;
        err = reg_err;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : access
endmodule : rtdcc_master_model

`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rtdcc_pkg::*;
    localparam int TICK = 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_rd, reg_wr, reg_ack, reg_err, ak, er, sample_valid = 1'b0;
    logic sensor_fault = 1'b0, module_fail = 1'b0, bus_suspect = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, q, v, shown = 16'h0000;
    logic [15:0] sample_value, sample_float_high, sample_float_low, sample_lead;
    rtdcc_sensor_type sensor_type;
    rtdcc_avg_type avg_mode;
    logic [2:0] exp_stage;
    logic measure_resistance, three_wire, reject_60hz, resistance_fine, update_busy;
    logic power_lamp, error_lamp, receive_lamp, transmit_lamp;
    int errors = 0, checks_done = 0, cycles = 0, n;

    always #4 sys_clk = ~sys_clk;

    rtdcc_channel_regs #(.MS_TICK(TICK)) rtdcc_channel_regs_inst (.sys_clk(sys_clk),
        .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .sample_valid(sample_valid), .sample_value(sample_value),
        .sample_float_high(sample_float_high), .sample_float_low(sample_float_low),
        .sample_lead(sample_lead), .sensor_fault(sensor_fault), .module_fail(module_fail),
        .bus_suspect(bus_suspect), .sensor_type(sensor_type),
        .measure_resistance(measure_resistance), .three_wire(three_wire),
        .reject_60hz(reject_60hz), .avg_mode(avg_mode), .exp_stage(exp_stage),
        .resistance_fine(resistance_fine), .update_busy(update_busy),
        .power_lamp(power_lamp), .error_lamp(error_lamp), .receive_lamp(receive_lamp),
        .transmit_lamp(transmit_lamp));

    rtdcc_master_model rtdcc_master_model_inst (.sys_clk(sys_clk), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        rtdcc_master_model_inst.access(1'b1, a, d, q, ak, er);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        rtdcc_master_model_inst.access(1'b0, a, 16'h0000, q, ak, er);
        check(q, exp);
    endtask : rd

    // One input step; busy time against the propagation time
    task automatic step(input logic [15:0] cfg, input logic [15:0] d, input int ms);
        wr(ADDR_CONFIG_WORD, cfg);
        shown = shown + d;
        sample_value = shown;
        sample_float_high = ~shown;
        sample_float_low = shown ^ 16'h5a5a;
        sample_lead = d;
        sample_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        sample_valid = 1'b0;
        n = 0;
        while (update_busy === 1'b1 && n < 2000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(16'((n >= (ms - 1) * TICK && n <= ms * TICK + 1) ? ms : n), 16'(ms));
        rd(ADDR_SCALED_MEASURE, shown);
        rd(ADDR_FLOAT_HIGH, ~shown);
        rd(ADDR_FLOAT_LOW, shown ^ 16'h5a5a);
        rd(ADDR_LEAD_RESISTANCE, d);
    endtask : step

    // Hang guard well above the cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        rd(ADDR_CONFIG_WORD, CONFIG_RESET);
        rd(ADDR_FALLBACK_VALUE, FALLBACK_RESET);
        rd(16'h9c47, 16'h0000);
        check(16'(er), 16'h0001);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            v = {8'ha5, 2'(i), 1'(i), 1'(i >> 1), 1'(i >> 2), 3'(i)};
            wr(ADDR_CONFIG_WORD, v);
            rd(ADDR_CONFIG_WORD, {8'h00, v[7:0]});
            check(16'(sensor_type), 16'(v[7:6]));
            check(16'({measure_resistance, three_wire, reject_60hz}), 16'(v[5:3]));
            check(16'({avg_mode, exp_stage}), (i > 2) ? 16'(24 + i - 2) : 16'(8 * i));
        end
        $display("test config done");
        wr(ADDR_CONFIG_WORD, 16'h0002);
        wr(ADDR_FALLBACK_VALUE, 16'h7d00);
        rd(ADDR_FALLBACK_VALUE, 16'h7d00);
        wr(ADDR_FALLBACK_VALUE, 16'h7d01);
        rd(ADDR_FALLBACK_VALUE, 16'h7d00);
        wr(ADDR_FALLBACK_VALUE, 16'h8300);
        rd(ADDR_FALLBACK_VALUE, 16'h8300);
        wr(ADDR_FALLBACK_VALUE, 16'h82ff);
        wr(ADDR_CONFIG_WORD, 16'h0022);
        wr(ADDR_FALLBACK_VALUE, 16'hffff);
        rd(ADDR_FALLBACK_VALUE, 16'h8300);
        wr(16'h9c00, 16'h1234);
        check(16'(er), 16'h0001);
        $display("test fallback done");
        step(16'h0000, 16'h0123, 45);
        step(16'h0008, 16'h0010, 37);
        step(16'h0001, 16'h0050, 103);
        step(16'h0001, 16'h004f, 236);
        step(16'h0041, 16'h0032, 103);
        step(16'h0082, 16'h0059, 405);
        step(16'h00c2, 16'h0032, 179);
        wr(ADDR_SCALED_MEASURE, 16'hbeef);
        wr(ADDR_FLOAT_LOW, 16'hbeef);
        rd(ADDR_SCALED_MEASURE, shown);
        rd(ADDR_FLOAT_LOW, shown ^ 16'h5a5a);
        $display("test samples done");
        sensor_fault = 1'b1;
        rd(ADDR_SCALED_MEASURE, 16'h8300);
        n = 0;
        v[0] = error_lamp;
        repeat (2 * ERR_BLINK_HALF_MS * TICK + 10)
        begin
            @(posedge sys_clk);
            #1;
            n += (error_lamp !== v[0]);
            v[0] = error_lamp;
        end
        check(16'(n >= 2), 16'h0001);
        sensor_fault = 1'b0;
        module_fail = 1'b1;
        bus_suspect = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        check(16'({error_lamp, transmit_lamp, receive_lamp}), 16'h0007);
        check(16'(power_lamp), 16'h0001);
        $display("test lamps done");
        give_verdict();
    end
endmodule : testbench

`default_nettype wire

// ==== src/rtdcc_channel_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

// Function
// - Sensor-type bits 7:6 decode as 00 Pt100, 01 Ni100, 10 Pt500, 11 Pt1000, resetting to 00.
// - Bit 5 picks temperature (0) or resistance (1) reporting and sets the measure units.
// - Bit 4 picks two/four-wire (0) or three-wire (1) sensor connection.
// - Bit 3 picks 50 Hz (0) or 60 Hz (1) rejection; 60 Hz divides every propagation time by 1.2.
// - Bits 2:0 hold the filter select, resetting to 010.
// - Filter codes mean off, 13-bit average, 14-bit average, and average plus exponential.
// - Update delay after a step is 45/236/405 ms or 1/3/8/24/72 s slow, 103 or 179 ms fast.
// - Steps at or over 8, 5, 9 or 5 degrees per sensor type take the fast response unless the filter is off.
// - A read-only integer measure word in tenths of a degree or hundredths/tenths of an ohm.
// - The measure as a 32-bit float, upper half first, lower half at the next address.
// - A read-only word gives the lead-wire resistance in milliohms.
// - The fallback value defaults to 8500; writes outside its temperature or resistance range are dropped.
// - The error lamp blinks on a reportable error and is steady on module failure.
// - The receive lamp flashes per received packet and is steady on a suspect bus.
// - The transmit lamp flashes per sent packet and is steady on module failure.
module rtdcc_channel_regs
    import rtdcc_pkg::*;
#(
    parameter int MS_TICK = MS_TICK_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst,
    // Register access
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    // Samples from the acquisition path
    input wire logic sample_valid,
    input wire logic [15:0] sample_value,
    input wire logic [15:0] sample_float_high,
    input wire logic [15:0] sample_float_low,
    input wire logic [15:0] sample_lead,
    input wire logic sensor_fault,
    input wire logic module_fail,
    input wire logic bus_suspect,
    // Decoded configuration and update status
    output rtdcc_pkg::rtdcc_sensor_type sensor_type,
    output logic measure_resistance,
    output logic three_wire,
    output logic reject_60hz,
    output rtdcc_pkg::rtdcc_avg_type avg_mode,
    output logic [2:0] exp_stage,
    output logic resistance_fine,
    output logic update_busy,
    // Front-panel lamps
    output logic power_lamp,
    output logic error_lamp,
    output logic receive_lamp,
    output logic transmit_lamp
);
    import rtdcc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } rtdcc_state_type;

    localparam logic [MS_WIDTH-1:0] PROP_TABLE_SLOW [8] = '{
        MS_WIDTH'(PROP_NONE_MS), MS_WIDTH'(PROP_AVG13_MS), MS_WIDTH'(PROP_AVG14_MS),
        MS_WIDTH'(PROP_EXP1_MS), MS_WIDTH'(PROP_EXP2_MS), MS_WIDTH'(PROP_EXP3_MS),
        MS_WIDTH'(PROP_EXP4_MS), MS_WIDTH'(PROP_EXP5_MS)
    };
    localparam int TICK_WIDTH = $clog2(MS_TICK + 1);
    localparam logic [TICK_WIDTH-1:0] TICK_LAST = TICK_WIDTH'(MS_TICK - 1);

    rtdcc_lamp_if lamp_bus ();

    logic [15:0] config_word;
    logic [15:0] fallback_value;
    logic [15:0] shown_value;
    logic [15:0] shown_float_high;
    logic [15:0] shown_float_low;
    logic [15:0] lead_value;
    logic [15:0] pend_value;
    logic [15:0] pend_float_high;
    logic [15:0] pend_float_low;
    logic [TICK_WIDTH-1:0] tick_cnt;
    logic ms_tick;
    logic [MS_WIDTH-1:0] wait_ms;
    logic [MS_WIDTH-1:0] next_wait_ms;
    rtdcc_state_type state;
    rtdcc_state_type next_state;
    rtdcc_filter_type filter_code;

    // Magnitude of a signed step
    function automatic logic [15:0] abs_diff(input logic [15:0] a,
        input logic [15:0] b);
        logic signed [16:0] d;
        d = 17'($signed(a)) - 17'($signed(b));
        abs_diff = d[16] ? 16'(-d) : d[15:0];
    endfunction : abs_diff

    function automatic logic [15:0] step_limit(input rtdcc_sensor_type s);
        step_limit = 16'h0000;
        case (s)
            SENSOR_PT100: step_limit = 16'(STEP_PT100_DEG * TENTHS_PER_DEG);
            SENSOR_NI100: step_limit = 16'(STEP_NI100_DEG * TENTHS_PER_DEG);
            SENSOR_PT500: step_limit = 16'(STEP_PT500_DEG * TENTHS_PER_DEG);
            SENSOR_PT1000: step_limit = 16'(STEP_PT1000_DEG * TENTHS_PER_DEG);
            default: step_limit = 16'(STEP_PT100_DEG * TENTHS_PER_DEG);
        endcase
    endfunction : step_limit

    // Address decode
    logic hit_measure;
    logic hit_float_high;
    logic hit_float_low;
    logic hit_lead;
    logic hit_config;
    logic hit_fallback;
    logic hit_any;
    logic access;
    assign hit_measure = (reg_addr == ADDR_SCALED_MEASURE);
    assign hit_float_high = (reg_addr == ADDR_FLOAT_HIGH);
    assign hit_float_low = (reg_addr == ADDR_FLOAT_LOW);
    assign hit_lead = (reg_addr == ADDR_LEAD_RESISTANCE);
    assign hit_config = (reg_addr == ADDR_CONFIG_WORD);
    assign hit_fallback = (reg_addr == ADDR_FALLBACK_VALUE);
    assign hit_any = hit_measure | hit_float_high | hit_float_low | hit_lead | hit_config
        | hit_fallback;
    assign access = reg_rd | reg_wr;

    // Configuration field decode
    assign sensor_type = rtdcc_sensor_type'(config_word[SENSOR_MSB:SENSOR_LSB]);
    assign measure_resistance = config_word[MEASURE_BIT];
    assign three_wire = config_word[WIRING_BIT];
    assign reject_60hz = config_word[REJECT_BIT];
    assign filter_code = rtdcc_filter_type'(config_word[FILTER_MSB:FILTER_LSB]);
    // Hundredths of an ohm for 100-ohm sensors, else tenths
    assign resistance_fine = measure_resistance
        && (sensor_type == SENSOR_PT100 || sensor_type == SENSOR_NI100);

    // Filter class decode
    assign avg_mode = (filter_code == FILT_NONE) ? AVG_OFF
        : (filter_code == FILT_AVG13) ? AVG_13BIT
        : (filter_code == FILT_AVG14) ? AVG_14BIT
        : AVG_14BIT_EXP;
    assign exp_stage = (avg_mode == AVG_14BIT_EXP) ? 3'(filter_code - FILT_AVG14)
        : 3'h0;

    // Fallback range check; out-of-range writes are dropped
    logic signed [15:0] wr_signed;
    logic fallback_ok;
    assign wr_signed = $signed(reg_wdata);
    assign fallback_ok = (wr_signed <= FALLBACK_MAX)
        && (wr_signed >= (measure_resistance ? FALLBACK_MIN_RES : FALLBACK_MIN_TEMP));

    // Only the two writable words are stored
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            config_word <= CONFIG_RESET;
            fallback_value <= FALLBACK_RESET;
        end
        else if (reg_wr)
        begin
            if (hit_config)
                config_word <= reg_wdata & CONFIG_USED_MASK;
            if (hit_fallback && fallback_ok)
                fallback_value <= reg_wdata;
        end
    end

    // Read mux; a fault shows the fallback in the integer word
    logic [15:0] read_mux;
    assign read_mux = hit_measure ? (sensor_fault ? fallback_value : shown_value)
        : hit_float_high ? shown_float_high
        : hit_float_low ? shown_float_low
        : hit_lead ? lead_value
        : hit_config ? config_word
        : hit_fallback ? fallback_value
        : 16'h0000;

    // Answer a cycle after the strobe; unmapped gives an error
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
        end
        else
        begin
            reg_ack <= access & hit_any;
            reg_err <= access & ~hit_any;
            if (reg_rd)
                reg_rdata <= read_mux;
        end
    end

    // Millisecond prescaler; timing against seconds-long filters in raw cycles
    // would need very wide counters
    assign ms_tick = (tick_cnt == TICK_LAST);
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tick_cnt <= '0;
        else if (ms_tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 1'b1;
    end

    // Propagation time for the step just seen
    logic step_fast;
    logic [MS_WIDTH-1:0] prop_50hz;
    logic [MS_WIDTH+2:0] prop_scaled;
    logic [MS_WIDTH-1:0] prop_ms;
    logic step_seen;
    assign step_fast = (abs_diff(sample_value, shown_value)
        >= step_limit(sensor_type));
    assign prop_50hz = (step_fast && avg_mode == AVG_13BIT) ? MS_WIDTH'(PROP_FAST13_MS)
        : (step_fast && avg_mode != AVG_OFF) ? MS_WIDTH'(PROP_FAST14_MS)
        : PROP_TABLE_SLOW[filter_code];
    assign prop_scaled = (MS_WIDTH + 3)'(prop_50hz)
        * (MS_WIDTH + 3)'(REJ60_NUM);
    assign prop_ms = reject_60hz ? MS_WIDTH'(prop_scaled / (MS_WIDTH + 3)'(REJ60_DEN))
        : prop_50hz;
    assign step_seen = sample_valid
        && (sample_value != shown_value);

    // Hold the new value back for the propagation time
    always_comb
    begin
        next_state = state;
        next_wait_ms = wait_ms;
        case (state)
            ST_IDLE:
            begin
                if (step_seen)
                begin
                    next_state = ST_WAIT;
                    next_wait_ms = prop_ms;
                end
            end
            ST_WAIT:
            begin
                if (ms_tick && wait_ms <= MS_WIDTH'(1))
                begin
                    next_state = ST_IDLE;
                    next_wait_ms = '0;
                end
                else if (ms_tick)
                    next_wait_ms = wait_ms - 1'b1;
            end
            default:
            begin
                next_state = ST_IDLE;
                next_wait_ms = '0;
            end
        endcase
    end

    logic load_shown;
    assign load_shown = (state == ST_WAIT) && (next_state == ST_IDLE);
    assign update_busy = (state == ST_WAIT);

    // State and wait registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            wait_ms <= '0;
        end
        else
        begin
            state <= next_state;
            wait_ms <= next_wait_ms;
        end
    end

    // Latest sample waits in pending words; the lead value is not filtered
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pend_value <= 16'h0000;
            pend_float_high <= 16'h0000;
            pend_float_low <= 16'h0000;
            lead_value <= 16'h0000;
        end
        else if (sample_valid)
        begin
            pend_value <= sample_value;
            pend_float_high <= sample_float_high;
            pend_float_low <= sample_float_low;
            lead_value <= sample_lead;
        end
    end

    // Shown words change only at the end of the wait
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            shown_value <= 16'h0000;
            shown_float_high <= 16'h0000;
            shown_float_low <= 16'h0000;
        end
        else if (load_shown)
        begin
            shown_value <= pend_value;
            shown_float_high <= pend_float_high;
            shown_float_low <= pend_float_low;
        end
    end

    // Lamp events: a strobe is a received packet, an answer a sent one
    assign lamp_bus.ms_tick = ms_tick;
    assign lamp_bus.rx_event = access;
    assign lamp_bus.tx_event = reg_ack | reg_err;
    assign lamp_bus.error_present = sensor_fault;
    assign lamp_bus.module_fail = module_fail;
    assign lamp_bus.bus_suspect = bus_suspect;

    // Lamp driver
    rtdcc_lamp_ctrl u_lamps
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .ev(lamp_bus.lamp),
        .power_lamp(power_lamp),
        .error_lamp(error_lamp),
        .receive_lamp(receive_lamp),
        .transmit_lamp(transmit_lamp)
    );
endmodule : rtdcc_channel_regs

`default_nettype wire

// ==== src/rtdcc_lamp_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module rtdcc_lamp_ctrl
    import rtdcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    rtdcc_lamp_if.lamp ev,
    output logic power_lamp,
    output logic error_lamp,
    output logic receive_lamp,
    output logic transmit_lamp
);
    localparam logic [LAMP_CNT_WIDTH-1:0] PULSE_LEN = LAMP_CNT_WIDTH'(LAMP_PULSE_MS);
    localparam logic [LAMP_CNT_WIDTH-1:0] HALF_LEN = LAMP_CNT_WIDTH'(ERR_BLINK_HALF_MS);

    logic [1:0] pkt_event;
    logic [1:0] pkt_lit;
    logic [LAMP_CNT_WIDTH-1:0] blink_cnt;
    logic blink_phase;
    logic blink_wrap;

    assign pkt_event = {ev.tx_event, ev.rx_event};
    assign blink_wrap = ev.ms_tick && (blink_cnt == HALF_LEN - 1'b1);

    // One pulse stretcher per packet lamp; a new packet restarts the flash
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_pulse
            logic [LAMP_CNT_WIDTH-1:0] left;
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                    left <= '0;
                else if (pkt_event[g])
                    left <= PULSE_LEN;
                else if (ev.ms_tick && left != '0)
                    left <= left - 1'b1;
            end
            assign pkt_lit[g] = (left != '0);
        end
    endgenerate

    // Free-running error blink phase
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end
        else if (blink_wrap)
        begin
            blink_cnt <= '0;
            blink_phase <= ~blink_phase;
        end
        else if (ev.ms_tick)
            blink_cnt <= blink_cnt + 1'b1;
    end

    // Steady light wins over blinking: a failure must not look like a packet
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            power_lamp <= 1'b0;
            error_lamp <= 1'b0;
            receive_lamp <= 1'b0;
            transmit_lamp <= 1'b0;
        end
        else
        begin
            power_lamp <= 1'b1;
            error_lamp <= ev.module_fail | (ev.error_present & blink_phase);
            receive_lamp <= ev.bus_suspect | pkt_lit[0];
            transmit_lamp <= ev.module_fail | pkt_lit[1];
        end
    end
endmodule : rtdcc_lamp_ctrl

`default_nettype wire

// ==== src/rtdcc_lamp_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Register bank events for the lamp driver
interface rtdcc_lamp_if;
    logic ms_tick;
    logic rx_event;
    logic tx_event;
    logic error_present;
    logic module_fail;
    logic bus_suspect;

    modport src
    (
        output ms_tick,
        output rx_event,
        output tx_event,
        output error_present,
        output module_fail,
        output bus_suspect
    );

    modport lamp
    (
        input ms_tick,
        input rx_event,
        input tx_event,
        input error_present,
        input module_fail,
        input bus_suspect
    );
endinterface : rtdcc_lamp_if

`default_nettype wire

// ==== src/rtdcc_pkg.sv ====
package rtdcc_pkg;

    // Register addresses
    localparam logic [15:0] ADDR_SCALED_MEASURE = 16'h9c46;
    localparam logic [15:0] ADDR_FLOAT_HIGH = 16'h9c4d;
    localparam logic [15:0] ADDR_FLOAT_LOW = 16'h9c4e;
    localparam logic [15:0] ADDR_LEAD_RESISTANCE = 16'h9c53;
    localparam logic [15:0] ADDR_CONFIG_WORD = 16'h9c68;
    localparam logic [15:0] ADDR_FALLBACK_VALUE = 16'h9c6d;

    // Reset values
    localparam logic [15:0] CONFIG_RESET = 16'h0002;
    localparam logic [15:0] FALLBACK_RESET = 16'h2134;
    localparam logic [15:0] CONFIG_USED_MASK = 16'h00ff;

    // Config field positions
    localparam int SENSOR_MSB = 7;
    localparam int SENSOR_LSB = 6;
    localparam int MEASURE_BIT = 5;
    localparam int WIRING_BIT = 4;
    localparam int REJECT_BIT = 3;
    localparam int FILTER_MSB = 2;
    localparam int FILTER_LSB = 0;

    typedef enum logic [1:0] {
        SENSOR_PT100 = 2'h0,
        SENSOR_NI100 = 2'h1,
        SENSOR_PT500 = 2'h2,
        SENSOR_PT1000 = 2'h3
    } rtdcc_sensor_type;

    typedef enum logic [2:0] {
        FILT_NONE = 3'h0,
        FILT_AVG13 = 3'h1,
        FILT_AVG14 = 3'h2,
        FILT_EXP1 = 3'h3,
        FILT_EXP2 = 3'h4,
        FILT_EXP3 = 3'h5,
        FILT_EXP4 = 3'h6,
        FILT_EXP5 = 3'h7
    } rtdcc_filter_type;

    // Averaging class
    typedef enum logic [1:0] {
        AVG_OFF = 2'h0,
        AVG_13BIT = 2'h1,
        AVG_14BIT = 2'h2,
        AVG_14BIT_EXP = 2'h3
    } rtdcc_avg_type;

    // Fallback limits
    localparam logic signed [15:0] FALLBACK_MIN_TEMP = -16'sd32000;
    localparam logic signed [15:0] FALLBACK_MIN_RES = 16'sd0;
    localparam logic signed [15:0] FALLBACK_MAX = 16'sd32000;

    // Step thresholds in degrees
    localparam int STEP_PT100_DEG = 8;
    localparam int STEP_NI100_DEG = 5;
    localparam int STEP_PT500_DEG = 9;
    localparam int STEP_PT1000_DEG = 5;
    localparam int TENTHS_PER_DEG = 10;

    // 50 Hz propagation times, in ms
    localparam int PROP_NONE_MS = 45;
    localparam int PROP_AVG13_MS = 236;
    localparam int PROP_AVG14_MS = 405;
    localparam int PROP_EXP1_MS = 1000;
    localparam int PROP_EXP2_MS = 3000;
    localparam int PROP_EXP3_MS = 8000;
    localparam int PROP_EXP4_MS = 24000;
    localparam int PROP_EXP5_MS = 72000;
    localparam int PROP_FAST13_MS = 103;
    localparam int PROP_FAST14_MS = 179;
    // 60 Hz divides by 1.2, done as times five over six
    localparam int REJ60_NUM = 5;
    localparam int REJ60_DEN = 6;
    localparam int MS_WIDTH = 17;

    // Millisecond tick at 125 MHz
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_TIME_NS = 1000000;
    localparam int MS_TICK_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

    // Lamp timing, in ms
    localparam int LAMP_PULSE_MS = 50;
    localparam int ERR_BLINK_HALF_MS = 250;
    localparam int LAMP_CNT_WIDTH = 9;

endpackage : rtdcc_pkg
